// ---- rtl/fast_detect_consts.vh ----
// Register indices, field positions, reset values and interrupt layout of the threshold alarm block
// Function
// - Alarm pin driven by detection only when enabled
// - Force bit set: pin takes force value
// - Force bit clear: pin follows detection
// - Compare magnitude with 13-bit split upper threshold
// - Compare magnitude with 13-bit split lower threshold
// - Dwell count below lower threshold clears pin
// - Next-sync bit clear: continuous monitor sync
// - Next-sync bit set: one edge, then clear
`ifndef FAST_DETECT_CONSTS_VH
`define FAST_DETECT_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_ALARM_CTRL 12'h245
`define IDX_UPPER_LOW 12'h247
`define IDX_UPPER_HIGH 12'h248
`define IDX_LOWER_LOW 12'h249
`define IDX_LOWER_HIGH 12'h24A
`define IDX_DWELL_LOW 12'h24B
`define IDX_DWELL_HIGH 12'h24C
`define IDX_SYNC_CTRL 12'h26F
`define IDX_IRQ_STATUS 12'h280
`define IDX_IRQ_ENABLE 12'h281
`define IDX_IRQ_CLEAR 12'h282

// Control field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_FORCE_VAL_BIT 2
`define CTRL_FORCE_BIT 3
`define SYNC_ENABLE_BIT 0
`define SYNC_NEXT_BIT 1
`define THR_HIGH_W 5

// Interrupt status bits
`define IRQ_ALARM_RISE_BIT 0
`define IRQ_ALARM_FALL_BIT 1
`define IRQ_SYNC_BIT 2
`define IRQ_W 3

// Reset values
`define RST_CTRL 4'h0
`define RST_THRESHOLD 13'h0000
`define RST_DWELL 16'h0000
`define RST_SYNC 2'h0
`define RST_IRQ 3'h0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- rtl/threshold_detector.v ----
// Upper/lower threshold comparison with dwell-timed release of the alarm
`timescale 1ns/1ps
module threshold_detector #(
   parameter MAG_W = 13,
   parameter DWELL_W = 16
) (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire ce_in,
   input wire enable_in,
   input wire sample_valid_in,
   input wire [MAG_W-1:0] magnitude_in,
   input wire [MAG_W-1:0] upper_in,
   input wire [MAG_W-1:0] lower_in,
   input wire [DWELL_W-1:0] dwell_in,
   output wire alarm_out
);
   reg alarm_q;
   reg [DWELL_W-1:0] count_q;

   assign alarm_out = alarm_q;

   // Disabling detection drops the alarm and rearms the dwell counter
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alarm_q <= 1'b0;
         count_q <= {DWELL_W{1'b0}};
      end else if (ce_in) begin
         if (!enable_in) begin
            alarm_q <= 1'b0;
            count_q <= dwell_in;
         end else if (sample_valid_in) begin
            if (magnitude_in > upper_in) begin
               alarm_q <= 1'b1;
               count_q <= dwell_in;
            end else if (magnitude_in < lower_in) begin
               // Counter loaded with the dwell value counts down while below the lower threshold
               if (count_q == {DWELL_W{1'b0}}) begin
                  alarm_q <= 1'b0;
               end else begin
                  count_q <= count_q - {{(DWELL_W-1){1'b0}}, 1'b1};
               end
            end else begin
               count_q <= dwell_in;
            end
         end
      end
   end
endmodule

// ---- rtl/adc_fast_detect_sync.v ----
// Threshold alarm and signal-monitor sync control with AXI4-Lite registers and interrupt
`timescale 1ns/1ps
`include "fast_detect_consts.vh"
module adc_fast_detect_sync #(
   parameter ADDR_W = 14,
   parameter MAG_W = 13,
   parameter DWELL_W = 16
) (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire ce_in,
   input wire [ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   output wire [1:0] s_axi_bresp_out,
   output wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   output wire [31:0] s_axi_rdata_out,
   output wire [1:0] s_axi_rresp_out,
   output wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire sample_valid_in,
   input wire [MAG_W-1:0] fine_magnitude_in,
   input wire sysref_in,
   output wire threshold_alarm_pin_out,
   output wire monitor_sync_out,
   output wire irq_out
);
   // Register index from a byte address, used by both read and write decode
   function [11:0] reg_index;
      input [ADDR_W-1:0] addr;
      begin
         reg_index = addr[13:2];
      end
   endfunction

   // Whether an index names a mapped register
   function is_mapped;
      input [11:0] idx;
      begin
         if (idx == `IDX_ALARM_CTRL) begin
            is_mapped = 1'b1;
         end else if ((idx >= `IDX_UPPER_LOW) && (idx <= `IDX_DWELL_HIGH)) begin
            is_mapped = 1'b1;
         end else if ((idx == `IDX_SYNC_CTRL) || (idx == `IDX_IRQ_STATUS)) begin
            is_mapped = 1'b1;
         end else if ((idx == `IDX_IRQ_ENABLE) || (idx == `IDX_IRQ_CLEAR)) begin
            is_mapped = 1'b1;
         end else begin
            is_mapped = 1'b0;
         end
      end
   endfunction

   reg [3:0] ctrl_q;
   reg [MAG_W-1:0] upper_q;
   reg [MAG_W-1:0] lower_q;
   reg [DWELL_W-1:0] dwell_q;
   reg [1:0] sync_q;
   reg [`IRQ_W-1:0] irq_status_q;
   reg [`IRQ_W-1:0] irq_status_d;
   reg [`IRQ_W-1:0] irq_enable_q;

   reg aw_have_q;
   reg w_have_q;
   reg [ADDR_W-1:0] awaddr_q;
   reg [7:0] wdata_q;
   reg wstrb0_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   reg sysref_prev_q;
   reg sync_pulse_q;
   reg alarm_prev_q;

   wire do_write;
   wire [11:0] widx;
   wire [11:0] ridx;
   wire wr_lane;
   wire sysref_edge;
   wire sync_fire;
   wire alarm_raw;
   reg pin_level;
   wire alarm_rise;
   wire alarm_fall;

   // ---------------- AXI4-Lite write channel ----------------
   assign s_axi_awready_out = !aw_have_q && !bvalid_q;
   assign s_axi_wready_out = !w_have_q && !bvalid_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign do_write = aw_have_q && w_have_q && !bvalid_q;
   assign widx = reg_index(awaddr_q);
   // Only byte lane 0 carries register data; other lanes are ignored
   assign wr_lane = do_write && wstrb0_q;

   // Address and data are held apart, so either may arrive first; ce_in low freezes the handshake too
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= {ADDR_W{1'b0}};
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_in[7:0];
            wstrb0_q <= s_axi_wstrb_in[0];
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ---------------- Configuration registers ----------------
   // Threshold halves land independently; set both before enabling detection
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_q <= `RST_CTRL;
         upper_q <= `RST_THRESHOLD;
         lower_q <= `RST_THRESHOLD;
         dwell_q <= `RST_DWELL;
         irq_enable_q <= `RST_IRQ;
      end else if (ce_in && wr_lane) begin
         if (widx == `IDX_ALARM_CTRL) begin
            ctrl_q <= {wdata_q[3:2], 1'b0, wdata_q[0]};
         end else if (widx == `IDX_UPPER_LOW) begin
            upper_q[7:0] <= wdata_q;
         end else if (widx == `IDX_UPPER_HIGH) begin
            upper_q[MAG_W-1:8] <= wdata_q[`THR_HIGH_W-1:0];
         end else if (widx == `IDX_LOWER_LOW) begin
            lower_q[7:0] <= wdata_q;
         end else if (widx == `IDX_LOWER_HIGH) begin
            lower_q[MAG_W-1:8] <= wdata_q[`THR_HIGH_W-1:0];
         end else if (widx == `IDX_DWELL_LOW) begin
            dwell_q[7:0] <= wdata_q;
         end else if (widx == `IDX_DWELL_HIGH) begin
            dwell_q[15:8] <= wdata_q;
         end else if (widx == `IDX_IRQ_ENABLE) begin
            irq_enable_q <= wdata_q[`IRQ_W-1:0];
         end
      end
   end

   // ---------------- Signal-monitor synchronization ----------------
   assign sysref_edge = sysref_in && !sysref_prev_q;
   // Continuous mode realigns on every edge; that only stays coherent if SYSREF divides evenly
   assign sync_fire = sysref_edge && sync_q[`SYNC_ENABLE_BIT];
   assign monitor_sync_out = sync_pulse_q;

   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_q <= `RST_SYNC;
         sysref_prev_q <= 1'b0;
         sync_pulse_q <= 1'b0;
      end else if (ce_in) begin
         sysref_prev_q <= sysref_in;
         sync_pulse_q <= sync_fire;
         // A software write in the same cycle rearms, so it takes priority over the self-clear
         if (wr_lane && (widx == `IDX_SYNC_CTRL)) begin
            sync_q <= wdata_q[1:0];
         end else if (sync_fire && sync_q[`SYNC_NEXT_BIT]) begin
            sync_q[`SYNC_ENABLE_BIT] <= 1'b0;
         end
      end
   end

   // ---------------- Threshold detection and pin ----------------
   threshold_detector #(
      .MAG_W(MAG_W),
      .DWELL_W(DWELL_W)
   ) u_detector (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .enable_in(ctrl_q[`CTRL_ENABLE_BIT]),
      .sample_valid_in(sample_valid_in),
      .magnitude_in(fine_magnitude_in),
      .upper_in(upper_q),
      .lower_in(lower_q),
      .dwell_in(dwell_q),
      .alarm_out(alarm_raw)
   );

   // Force overrides everything, including a disabled detector
   always @* begin
      if (ctrl_q[`CTRL_FORCE_BIT]) begin
         pin_level = ctrl_q[`CTRL_FORCE_VAL_BIT];
      end else if (ctrl_q[`CTRL_ENABLE_BIT]) begin
         pin_level = alarm_raw;
      end else begin
         pin_level = 1'b0;
      end
   end
   assign threshold_alarm_pin_out = pin_level;

   // ---------------- Interrupts ----------------
   assign alarm_rise = pin_level && !alarm_prev_q;
   assign alarm_fall = !pin_level && alarm_prev_q;

   always @* begin
      irq_status_d = irq_status_q;
      if (wr_lane && (widx == `IDX_IRQ_CLEAR)) begin
         irq_status_d = irq_status_d & ~wdata_q[`IRQ_W-1:0];
      end
      // Events set after the clear so that a coinciding event is not lost
      if (alarm_rise) begin
         irq_status_d[`IRQ_ALARM_RISE_BIT] = 1'b1;
      end
      if (alarm_fall) begin
         irq_status_d[`IRQ_ALARM_FALL_BIT] = 1'b1;
      end
      if (sync_fire) begin
         irq_status_d[`IRQ_SYNC_BIT] = 1'b1;
      end
   end

   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_status_q <= `RST_IRQ;
         alarm_prev_q <= 1'b0;
      end else if (ce_in) begin
         irq_status_q <= irq_status_d;
         alarm_prev_q <= pin_level;
      end
   end

   assign irq_out = |(irq_status_q & irq_enable_q);

   // ---------------- AXI4-Lite read channel ----------------
   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;
   assign ridx = reg_index(s_axi_araddr_in);

   // Read data is registered at the address handshake and stands until rready
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
            if (ridx == `IDX_ALARM_CTRL) begin
               rdata_q <= {28'h0000000, ctrl_q};
            end else if (ridx == `IDX_UPPER_LOW) begin
               rdata_q <= {24'h000000, upper_q[7:0]};
            end else if (ridx == `IDX_UPPER_HIGH) begin
               rdata_q <= {27'h0000000, upper_q[MAG_W-1:8]};
            end else if (ridx == `IDX_LOWER_LOW) begin
               rdata_q <= {24'h000000, lower_q[7:0]};
            end else if (ridx == `IDX_LOWER_HIGH) begin
               rdata_q <= {27'h0000000, lower_q[MAG_W-1:8]};
            end else if (ridx == `IDX_DWELL_LOW) begin
               rdata_q <= {24'h000000, dwell_q[7:0]};
            end else if (ridx == `IDX_DWELL_HIGH) begin
               rdata_q <= {24'h000000, dwell_q[15:8]};
            end else if (ridx == `IDX_SYNC_CTRL) begin
               rdata_q <= {30'h00000000, sync_q};
            end else if (ridx == `IDX_IRQ_STATUS) begin
               rdata_q <= {29'h00000000, irq_status_q};
            end else if (ridx == `IDX_IRQ_ENABLE) begin
               rdata_q <= {29'h00000000, irq_enable_q};
            end else if (ridx == `IDX_IRQ_CLEAR) begin
               // Clear register is write-only and reads as zero
               rdata_q <= 32'h00000000;
            end else begin
               rdata_q <= 32'h00000000;
            end
         end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_q <= 1'b0;
         end
      end
   end
endmodule

// ---- verif/agc_watch.sv ----
// Far-side gain control model counting alarm assertions
`timescale 1ns/1ps
module agc_watch (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire alarm_in,
   output wire [7:0] hits_out
);
   reg [7:0] hits_q;
   reg last_q;
   assign hits_out = hits_q;
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         last_q <= 1'b0;
         hits_q <= 8'h00;
      end else begin
         last_q <= alarm_in;
         if (alarm_in && !last_q) hits_q <= hits_q + 8'h01;
      end
   end
endmodule

// ---- verif/adc_fast_detect_sync_props.sv ----
// Bus handshake and pin timing checks for the threshold alarm block
`timescale 1ns/1ps
module adc_fast_detect_sync_props (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire s_axi_awvalid_in,
   input wire s_axi_awready_out,
   input wire s_axi_wvalid_in,
   input wire s_axi_wready_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire sample_valid_in,
   input wire sysref_in,
   input wire threshold_alarm_pin_out,
   input wire monitor_sync_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data not held");
   a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while busy");
   a_aw_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while busy");
   a_read_lat: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_write_lat: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> ##1 s_axi_bvalid_out) else $error("write answer late");
   a_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_sync_cause: assert property (monitor_sync_out |-> $past(sysref_in) && !$past(sysref_in, 2))
      else $error("sync pulse without edge");
   // Pin moves only after a sample or a committed write
   a_pin_cause: assert property ($changed(threshold_alarm_pin_out) |-> $past(sample_valid_in) ||
      s_axi_bvalid_out || $past(s_axi_bvalid_out)) else $error("pin changed without cause");
endmodule

// ---- verif/adc_fast_detect_sync_bench.sv ----
// Self-checking bench for the threshold alarm block
`timescale 1ns/1ps
`include "fast_detect_consts.vh"
module adc_fast_detect_sync_bench;
   reg clk_sys_in = 1'b0;
   reg rstn_in = 1'b0;
   reg [13:0] awaddr = 14'h0000, araddr = 14'h0000;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sv = 1'b0, sysref = 1'b0;
   reg [31:0] wdata = 32'h00000000;
   reg [31:0] got;
   reg [12:0] mag = 13'h0000;
   reg [1:0] rsp;
   wire awready, wready, bvalid, arready, rvalid, pin, sync, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] hits;
   integer n_errors = 0, checks_done = 0, cyc = 0, n_sync = 0, stall = 0, i;
   typedef struct { reg [11:0] idx; reg [7:0] wv; reg [7:0] rv; reg [1:0] resp; } row_t;
   row_t rows [0:9];
   always #10 clk_sys_in = ~clk_sys_in;
   adc_fast_detect_sync dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(1'b1),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .sample_valid_in(sv), .fine_magnitude_in(mag), .sysref_in(sysref),
      .threshold_alarm_pin_out(pin), .monitor_sync_out(sync), .irq_out(irq));
   agc_watch agc_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .alarm_in(pin), .hits_out(hits));
   task summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      checks_done = checks_done + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Both channels are offered together; each is released at the edge that takes it
   task wr(input [11:0] idx, input [7:0] d);
      reg aw_done;
      reg w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_sys_in);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (stall == 0);
      while (!(aw_done && w_done)) begin
         @(posedge clk_sys_in);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // A stalling master lets the response stand before taking it
      repeat (stall) @(posedge clk_sys_in);
      bready <= 1'b1;
      do @(posedge clk_sys_in); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task rd(input [11:0] idx);
      @(posedge clk_sys_in);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= (stall == 0);
      do @(posedge clk_sys_in); while (!arready);
      arvalid <= 1'b0;
      repeat (stall) @(posedge clk_sys_in);
      rready <= 1'b1;
      do @(posedge clk_sys_in); while (!rvalid);
      got = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task smp(input [12:0] m);
      @(posedge clk_sys_in);
      sv <= 1'b1;
      mag <= m;
      @(posedge clk_sys_in);
      sv <= 1'b0;
      #1;
   endtask
   // Edges spaced eight cycles apart, a whole number of monitor periods
   task edge_sr;
      @(posedge clk_sys_in);
      sysref <= 1'b1;
      @(posedge clk_sys_in);
      sysref <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
   endtask
   always @(posedge clk_sys_in) begin
      cyc = cyc + 1;
      if (sync === 1'b1) n_sync = n_sync + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         summarize;
      end
   end
   initial begin
      rows[0] = '{`IDX_ALARM_CTRL, 8'hFF, 8'h0D, `RESP_OKAY};
      rows[1] = '{`IDX_UPPER_LOW, 8'hA5, 8'hA5, `RESP_OKAY};
      rows[2] = '{`IDX_UPPER_HIGH, 8'hFF, 8'h1F, `RESP_OKAY};
      rows[3] = '{`IDX_LOWER_LOW, 8'h5A, 8'h5A, `RESP_OKAY};
      rows[4] = '{`IDX_LOWER_HIGH, 8'hFF, 8'h1F, `RESP_OKAY};
      rows[5] = '{`IDX_DWELL_LOW, 8'h3C, 8'h3C, `RESP_OKAY};
      rows[6] = '{`IDX_DWELL_HIGH, 8'hC3, 8'hC3, `RESP_OKAY};
      rows[7] = '{`IDX_IRQ_ENABLE, 8'hFF, 8'h07, `RESP_OKAY};
      rows[8] = '{`IDX_IRQ_CLEAR, 8'hFF, 8'h00, `RESP_OKAY};
      rows[9] = '{12'h300, 8'hFF, 8'h00, `RESP_SLVERR};
      repeat (6) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
         rd(rows[i].idx);
         chk(got, 32'h00000000);
         wr(rows[i].idx, rows[i].wv);
         chk(rsp, rows[i].resp);
         rd(rows[i].idx);
         chk(got, rows[i].rv);
         chk(rsp, rows[i].resp);
      end
      $display("test registers done");
      wr(`IDX_ALARM_CTRL, 8'h00);
      wr(`IDX_IRQ_CLEAR, 8'h07);
      wr(`IDX_UPPER_LOW, 8'h64);
      wr(`IDX_UPPER_HIGH, 8'h01);
      wr(`IDX_LOWER_LOW, 8'h32);
      wr(`IDX_LOWER_HIGH, 8'h01);
      wr(`IDX_DWELL_LOW, 8'h02);
      wr(`IDX_DWELL_HIGH, 8'h00);
      wr(`IDX_ALARM_CTRL, 8'h01);
      smp(13'h0164);
      chk(pin, 1'b0);
      smp(13'h0165);
      chk(pin, 1'b1);
      // Status is set one edge after the pin rises
      @(posedge clk_sys_in);
      #1;
      chk(irq, 1'b1);
      // Third below-lower sample releases the pin with a dwell of two
      for (i = 0; i < 3; i = i + 1) begin
         smp(13'h0131);
         chk(pin, i < 2);
      end
      // The forced pin of the register rows was the first rise
      chk(hits, 8'h02);
      rd(`IDX_IRQ_STATUS);
      chk(got, 32'h00000003);
      wr(`IDX_IRQ_ENABLE, 8'h00);
      smp(13'h0165);
      chk(irq, 1'b0);
      wr(`IDX_IRQ_ENABLE, 8'h07);
      chk(irq, 1'b1);
      wr(`IDX_IRQ_CLEAR, 8'h07);
      chk(irq, 1'b0);
      $display("test detection done");
      wr(`IDX_ALARM_CTRL, 8'h09);
      chk(pin, 1'b0);
      // Force released while detection holds the alarm: pin must follow detection again
      wr(`IDX_ALARM_CTRL, 8'h01);
      chk(pin, 1'b1);
      wr(`IDX_ALARM_CTRL, 8'h00);
      smp(13'h1FFF);
      chk(pin, 1'b0);
      $display("test force done");
      wr(`IDX_SYNC_CTRL, 8'h01);
      edge_sr;
      edge_sr;
      chk(n_sync, 32'h00000002);
      wr(`IDX_SYNC_CTRL, 8'h03);
      edge_sr;
      edge_sr;
      chk(n_sync, 32'h00000003);
      rd(`IDX_SYNC_CTRL);
      chk(got, 32'h00000002);
      rd(`IDX_IRQ_STATUS);
      chk(got, 32'h00000007);
      $display("test sync done");
      // Master holds off its ready so responses must stand
      stall = 3;
      wr(`IDX_DWELL_LOW, 8'h77);
      chk(rsp, `RESP_OKAY);
      rd(`IDX_DWELL_LOW);
      chk(got, 32'h00000077);
      stall = 0;
      $display("test stalled bus done");
      // Mid-run reset drops the forced pin and the interrupt
      wr(`IDX_ALARM_CTRL, 8'h0C);
      chk(pin, 1'b1);
      @(posedge clk_sys_in);
      rstn_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      #1;
      chk(pin, 1'b0);
      chk(irq, 1'b0);
      @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      rd(`IDX_ALARM_CTRL);
      chk(got, 32'h00000000);
      rd(`IDX_UPPER_LOW);
      chk(got, 32'h00000000);
      $display("test reset done");
      summarize;
   end
endmodule
bind adc_fast_detect_sync adc_fast_detect_sync_props chk_u (.*);
